// ==== verilog/aob_datapath.sv ====
// execution datapath for add, and, bit set/clear and bit-test-skip
`timescale 1ns/100ps
`include "aob_defines.svh"

// Functional notes
// RULE1: literal add into accumulator, all flags
// RULE2: accumulator plus file register, all flags
// RULE3: target bit picks accumulator or register
// RULE4: literal and into accumulator, null only
// RULE5: register and to target, null only
// RULE6: clear selected bit, flags untouched
// RULE7: set selected bit, flags untouched
// RULE8: skip next when tested bit one
// RULE9: skip next when tested bit zero
// RULE10: port registers read from pins
// RULE11: skip second cycle runs idle
// RULE12: carries from bits three, seven; zero
module aob_datapath
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// decoded instruction
	input  wire logic                     instr_valid,
	input  wire logic [3:0]               instr_op,
	input  wire logic [7:0]               literal_value,
	input  wire logic [6:0]               register_location,
	input  wire logic [2:0]               selected_position,
	input  wire logic                     result_target,
	// file register read side
	input  wire logic [7:0]               file_rd_data,
	input  wire logic [7:0]               port_pin_data,
	input  wire logic                     file_is_port,
	// file register write side
	output logic [6:0]                    file_addr,
	output logic                          file_wr_en,
	output logic [7:0]                    file_wr_data,
	// architectural state
	output logic [7:0]                    accumulator,
	output logic                          ninth_result_bit,
	output logic                          nibble_overflow_flag,
	output logic                          result_null_flag,
	// sequencing
	output logic                          idle_cycle,
	output logic                          instr_ready
);
	typedef struct packed
	{
		logic [7:0]          acc;
		logic                carry;
		logic                nib;
		logic                zero;
		aob_pkg::aob_state_e st;
		logic [6:0]          waddr;
		logic                wen;
		logic [7:0]          wdata;
	} aob_state_s;

	aob_state_s state_q;
	aob_state_s state_d;

	aob_file_if fif ();

	logic [7:0] operand;
	logic [7:0] bit_cleared;
	logic [7:0] bit_set;
	logic       bit_tested;

	// ------------------------------------------------------------------
	// operand path
	// ------------------------------------------------------------------
	assign fif.addr       = register_location;
	assign fif.latch_data = file_rd_data;
	assign fif.pin_data   = port_pin_data;
	assign fif.is_port    = file_is_port;
	assign operand        = fif.operand;

	aob_operand_fetch u_fetch
	(
		.fif (fif.fetch)
	);

	aob_bit_unit u_bits
	(
		.value    (operand),
		.position (selected_position),
		.cleared  (bit_cleared),
		.set_val  (bit_set),
		.tested   (bit_tested)
	);

	// ------------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------------
	logic op_add_lit;
	logic op_add_reg;
	logic op_and_lit;
	logic op_and_reg;
	logic op_to_file;
	logic run_slot;
	logic taken;

	assign op_add_lit = (instr_op == aob_pkg::AOB_OP_ADD_LIT);
	assign op_add_reg = (instr_op == aob_pkg::AOB_OP_ADD_REG);
	assign op_and_lit = (instr_op == aob_pkg::AOB_OP_AND_LIT);
	assign op_and_reg = (instr_op == aob_pkg::AOB_OP_AND_REG);
	// only the register forms honour the target bit; literal forms
	// always land in the accumulator
	assign op_to_file = (op_add_reg | op_and_reg)
		& (result_target == `AOB_DEST_FILE);
	assign run_slot   = (state_q.st == aob_pkg::AOB_ST_RUN);
	// an instruction offered in the idle slot is the discarded one
	assign taken      = instr_valid & run_slot;

	// ------------------------------------------------------------------
	// arithmetic and logic results
	// ------------------------------------------------------------------
	logic [7:0] addend;
	logic [7:0] mask_src;
	logic [4:0] low_sum;
	logic [8:0] full_sum;
	logic [7:0] add_res;
	logic [7:0] and_res;
	logic       nib_carry;
	logic       byte_carry;
	logic       add_zero;
	logic       and_zero;
	logic       skip;

	// literal forms take the instruction field, register forms the operand
	assign addend     = op_add_lit ? literal_value : operand;
	assign mask_src   = op_and_lit ? literal_value : operand;
	// RULE12: nibble and byte carries
	// the low nibble is summed on its own so its carry needs no xor trick
	assign low_sum    = {1'b0, state_q.acc[3:0]} + {1'b0, addend[3:0]};
	assign full_sum   = {1'b0, state_q.acc} + {1'b0, addend};
	assign add_res    = full_sum[7:0];
	assign nib_carry  = low_sum[`AOB_NIBBLE_BIT];
	assign byte_carry = full_sum[`AOB_DATA_W];
	assign add_zero   = (add_res == 8'h00);
	assign and_res    = state_q.acc & mask_src;
	assign and_zero   = (and_res == 8'h00);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		state_d       = state_q;
		state_d.wen   = 1'b0;
		state_d.wdata = state_q.wdata;
		skip          = 1'b0;
		if (!run_slot)
		begin
			// RULE11: discarded slot runs idle
			state_d.st = aob_pkg::AOB_ST_RUN;
		end
		else if (taken)
		begin
			unique case (aob_pkg::aob_op_e'(instr_op))
				aob_pkg::AOB_OP_ADD_LIT:
				begin
					// RULE1: literal add, all flags
					state_d.acc   = add_res;
					state_d.carry = byte_carry;
					state_d.nib   = nib_carry;
					state_d.zero  = add_zero;
				end
				aob_pkg::AOB_OP_ADD_REG:
				begin
					// RULE2: register add, all flags
					state_d.carry = byte_carry;
					state_d.nib   = nib_carry;
					state_d.zero  = add_zero;
					// RULE3: destination select
					if (op_to_file)
					begin
						state_d.wen   = 1'b1;
						state_d.wdata = add_res;
					end
					else
						state_d.acc = add_res;
				end
				aob_pkg::AOB_OP_AND_LIT:
				begin
					// RULE4: literal mask, null only
					state_d.acc  = and_res;
					state_d.zero = and_zero;
				end
				aob_pkg::AOB_OP_AND_REG:
				begin
					// RULE5: register mask, null only
					state_d.zero = and_zero;
					// RULE3: destination select
					if (op_to_file)
					begin
						state_d.wen   = 1'b1;
						state_d.wdata = and_res;
					end
					else
						state_d.acc = and_res;
				end
				aob_pkg::AOB_OP_CLR_BIT:
				begin
					// RULE6: clear bit write back
					state_d.wen   = 1'b1;
					state_d.wdata = bit_cleared;
				end
				aob_pkg::AOB_OP_SET_BIT:
				begin
					// RULE7: set bit write back
					state_d.wen   = 1'b1;
					state_d.wdata = bit_set;
				end
				aob_pkg::AOB_OP_SKIP_ONE:
					// RULE8: skip on one
					skip = bit_tested;
				aob_pkg::AOB_OP_SKIP_ZERO:
					// RULE9: skip on zero
					skip = ~bit_tested;
				default:
					skip = 1'b0;
			endcase
			if (skip)
				state_d.st = aob_pkg::AOB_ST_IDLE;
			if (state_d.wen)
				state_d.waddr = register_location;
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q.acc   <= `AOB_ACC_RST;
			state_q.carry <= 1'b0;
			state_q.nib   <= 1'b0;
			state_q.zero  <= 1'b0;
			state_q.st    <= aob_pkg::AOB_ST_RUN;
			state_q.waddr <= 7'h00;
			state_q.wen   <= 1'b0;
			state_q.wdata <= 8'h00;
		end
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign accumulator          = state_q.acc;
	assign ninth_result_bit     = state_q.carry;
	assign nibble_overflow_flag = state_q.nib;
	assign result_null_flag     = state_q.zero;
	assign file_addr            = state_q.waddr;
	assign file_wr_en           = state_q.wen;
	assign file_wr_data         = state_q.wdata;
	// the decoder holds the discarded instruction during the idle slot
	assign idle_cycle           = (state_q.st == aob_pkg::AOB_ST_IDLE);
	assign instr_ready          = ~idle_cycle;
endmodule

// ==== verilog/aob_defines.svh ====
// constants for the add and bit-operation datapath
`ifndef AOB_DEFINES_SVH
`define AOB_DEFINES_SVH

`define AOB_DATA_W       8
`define AOB_ADDR_W       7
`define AOB_BITSEL_W     3
`define AOB_NIBBLE_BIT   4
`define AOB_OP_W         4
`define AOB_ACC_RST      8'h00
`define AOB_DEST_ACC     1'b0
`define AOB_DEST_FILE    1'b1

`endif

// ==== verilog/aob_pkg.sv ====
// types shared by the add and bit-operation datapath
package aob_pkg;

	typedef enum logic [3:0]
	{
		AOB_OP_IDLE      = 4'b0000,
		AOB_OP_ADD_LIT   = 4'b0001,
		AOB_OP_ADD_REG   = 4'b0010,
		AOB_OP_AND_LIT   = 4'b0011,
		AOB_OP_AND_REG   = 4'b0100,
		AOB_OP_CLR_BIT   = 4'b0101,
		AOB_OP_SET_BIT   = 4'b0110,
		AOB_OP_SKIP_ONE  = 4'b0111,
		AOB_OP_SKIP_ZERO = 4'b1000
	} aob_op_e;

	typedef enum logic [0:0]
	{
		AOB_ST_RUN  = 1'b0,
		AOB_ST_IDLE = 1'b1
	} aob_state_e;

endpackage

// ==== verilog/aob_file_if.sv ====
// file register access bundle between core and operand fetch
`timescale 1ns/100ps

interface aob_file_if;
	logic [6:0] addr;
	logic [7:0] latch_data;
	logic [7:0] pin_data;
	logic       is_port;
	logic [7:0] operand;

	modport fetch
	(
		input  addr,
		input  latch_data,
		input  pin_data,
		input  is_port,
		output operand
	);
	modport core
	(
		output addr,
		output latch_data,
		output pin_data,
		output is_port,
		input  operand
	);
endinterface

// ==== verilog/aob_operand_fetch.sv ====
// source operand selection for read-modify-write of file registers
`timescale 1ns/100ps

module aob_operand_fetch
(
	// file register bundle
	aob_file_if.fetch fif
);
	// RULE10: pins over latch
	// port registers are read from the pins so that an input-driven pin
	// is written back with its real level
	assign fif.operand = fif.is_port ? fif.pin_data : fif.latch_data;
endmodule

// ==== verilog/aob_bit_unit.sv ====
// single-bit select, set and clear
`timescale 1ns/100ps

module aob_bit_unit
(
	// operand
	input  wire logic [7:0] value,
	input  wire logic [2:0] position,
	// results
	output logic [7:0]      cleared,
	output logic [7:0]      set_val,
	output logic            tested
);
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_bit
			// RULE6: force bit low
			assign cleared[i] = (position == 3'(i)) ? 1'b0 : value[i];
			// RULE7: force bit high
			assign set_val[i] = (position == 3'(i)) ? 1'b1 : value[i];
		end
	endgenerate
	assign tested = value[position];
endmodule

// ==== bench/aob_datapath_chk.sv ====
// port checker for the add and bit-operation datapath
`timescale 1ns/100ps

module aob_datapath_chk
(
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// decoded instruction
	input wire logic       instr_valid,
	input wire logic [3:0] instr_op,
	input wire logic [7:0] literal_value,
	input wire logic [6:0] register_location,
	input wire logic [2:0] selected_position,
	input wire logic       result_target,
	// file register side
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] port_pin_data,
	input wire logic       file_is_port,
	input wire logic [6:0] file_addr,
	input wire logic       file_wr_en,
	input wire logic [7:0] file_wr_data,
	// state and sequencing
	input wire logic [7:0] accumulator,
	input wire logic       ninth_result_bit,
	input wire logic       nibble_overflow_flag,
	input wire logic       result_null_flag,
	input wire logic       idle_cycle,
	input wire logic       instr_ready
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic       tk;
	logic       bt;
	logic [7:0] opd;
	logic [7:0] msk;
	assign tk = instr_valid & instr_ready;
	// port registers take the pin levels, not the latch
	assign opd = file_is_port ? port_pin_data : file_rd_data;
	assign bt = opd[selected_position];
	assign msk = 8'h01 << selected_position;
	// addend as the datapath picks it for the two add forms
	logic [7:0] add_in;
	assign add_in = (instr_op == 4'h1) ? literal_value : opd;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	add_lit_a: assert property (
		tk && instr_op == 4'h1 |=> {ninth_result_bit, accumulator}
		== $past(accumulator) + $past(literal_value))
		else $error("literal add wrong");
	add_reg_a: assert property (
		tk && instr_op == 4'h2 && !result_target
		|=> {ninth_result_bit, accumulator}
		== $past(accumulator) + $past(opd))
		else $error("register add wrong");
	to_file_a: assert property (
		tk && instr_op == 4'h2 && result_target
		|=> file_wr_en && file_addr == $past(register_location)
		&& file_wr_data == $past(accumulator) + $past(opd)
		&& $stable(accumulator))
		else $error("file target wrong");
	and_lit_a: assert property (
		tk && instr_op == 4'h3
		|=> accumulator == ($past(accumulator) & $past(literal_value))
		&& $stable(ninth_result_bit))
		else $error("literal and wrong");
	and_reg_a: assert property (
		tk && instr_op == 4'h4
		|=> result_null_flag
		== (($past(accumulator) & $past(opd)) == 8'h00)
		&& $stable(ninth_result_bit) && $stable(nibble_overflow_flag))
		else $error("register and wrong");
	zero_flag_a: assert property (
		tk && instr_op inside {4'h1, 4'h3}
		|=> result_null_flag == (accumulator == 8'h00))
		else $error("zero flag wrong");
	nib_carry_a: assert property (
		tk && instr_op inside {4'h1, 4'h2}
		|=> nibble_overflow_flag
		== ($past(accumulator[3:0]) + $past(add_in[3:0]) > 5'h0f))
		else $error("nibble carry wrong");
	clr_bit_a: assert property (
		tk && instr_op == 4'h5
		|=> file_wr_en && file_wr_data == ($past(opd) & ~$past(msk))
		&& $stable(result_null_flag))
		else $error("bit clear wrong");
	set_bit_a: assert property (
		tk && instr_op == 4'h6
		|=> file_wr_en && file_wr_data == ($past(opd) | $past(msk))
		&& $stable(ninth_result_bit))
		else $error("bit set wrong");
	skip_one_a: assert property (
		tk && instr_op == 4'h7 |=> idle_cycle == $past(bt))
		else $error("skip on one wrong");
	skip_zero_a: assert property (
		tk && instr_op == 4'h8 |=> idle_cycle == !$past(bt))
		else $error("skip on zero wrong");
	idle_slot_a: assert property (
		idle_cycle |-> !instr_ready ##1 (!idle_cycle
		&& $stable(accumulator) && !file_wr_en
		&& $stable({ninth_result_bit, nibble_overflow_flag,
		result_null_flag})))
		else $error("idle slot not idle");
	cover property (tk && instr_op == 4'h7 ##1 idle_cycle);
	cover property (file_wr_en);
	cover property (ninth_result_bit && nibble_overflow_flag);
endmodule

bind aob_datapath aob_datapath_chk aob_datapath_chk_inst
(
	.clk                  (clk),
	.sys_rst              (sys_rst),
	.instr_valid          (instr_valid),
	.instr_op             (instr_op),
	.literal_value        (literal_value),
	.register_location    (register_location),
	.selected_position    (selected_position),
	.result_target        (result_target),
	.file_rd_data         (file_rd_data),
	.port_pin_data        (port_pin_data),
	.file_is_port         (file_is_port),
	.file_addr            (file_addr),
	.file_wr_en           (file_wr_en),
	.file_wr_data         (file_wr_data),
	.accumulator          (accumulator),
	.ninth_result_bit     (ninth_result_bit),
	.nibble_overflow_flag (nibble_overflow_flag),
	.result_null_flag     (result_null_flag),
	.idle_cycle           (idle_cycle),
	.instr_ready          (instr_ready)
);

// ==== bench/aob_datapath_tb.sv ====
// self-checking bench for the add and bit-operation datapath
`timescale 1ns/100ps

module aob_datapath_tb;
	logic       clk = 0, sys_rst = 1, instr_valid = 0, result_target = 0;
	logic       file_is_port = 0, file_wr_en, ninth_result_bit;
	logic       nibble_overflow_flag, result_null_flag, idle_cycle;
	logic       instr_ready, c = 0, n = 0, z = 0;
	logic [3:0] instr_op = 0;
	logic [7:0] literal_value = 0, file_rd_data = 0, port_pin_data = 0;
	logic [7:0] accumulator, file_wr_data, a = 0;
	logic [6:0] register_location = 0, file_addr;
	logic [2:0] selected_position = 0;
	logic [7:0] lv [6] = '{8'hff, 8'h01, 8'h0f, 8'h01, 8'h80, 8'h80};
	int         n_fail = 0, num_checks = 0;

	always #10 clk = ~clk;

	aob_datapath aob_datapath_inst
	(
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.instr_valid          (instr_valid),
		.instr_op             (instr_op),
		.literal_value        (literal_value),
		.register_location    (register_location),
		.selected_position    (selected_position),
		.result_target        (result_target),
		.file_rd_data         (file_rd_data),
		.port_pin_data        (port_pin_data),
		.file_is_port         (file_is_port),
		.file_addr            (file_addr),
		.file_wr_en           (file_wr_en),
		.file_wr_data         (file_wr_data),
		.accumulator          (accumulator),
		.ninth_result_bit     (ninth_result_bit),
		.nibble_overflow_flag (nibble_overflow_flag),
		.result_null_flag     (result_null_flag),
		.idle_cycle           (idle_cycle),
		.instr_ready          (instr_ready)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task ck(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("BAD %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task cs;
		ck("state", {5'h00, a, c, n, z}, {5'h00, accumulator,
			ninth_result_bit, nibble_overflow_flag, result_null_flag});
	endtask
	// latch gets the inverse in port mode, so a wrong source shows
	task drv(input logic [3:0] o, input logic [7:0] v, input logic [2:0] b,
		input logic t, p);
		instr_op <= o;
		literal_value <= v;
		register_location <= v[6:0];
		port_pin_data <= v;
		file_rd_data <= p ? ~v : v;
		file_is_port <= p;
		selected_position <= b;
		result_target <= t;
		instr_valid <= 1'b1;
	endtask
	task op(input logic [3:0] o, input logic [7:0] v, input logic [2:0] b,
		input logic t, p);
		logic [8:0] s;
		logic [7:0] r;
		logic       f;
		s = a + v;
		f = o > 4 || t && (o == 2 || o == 4);
		r = o < 3 ? s[7:0] : o < 5 ? a & v :
			o == 5 ? v & ~(8'h01 << b) : v | (8'h01 << b);
		if (o < 3)
			{c, n} = {s[8], a[3:0] + v[3:0] > 5'h0f};
		if (o < 5)
			z = r == 8'h00;
		if (!f)
			a = r;
		@(posedge clk) drv(o, v, b, t, p);
		@(posedge clk) instr_valid <= 1'b0;
		#1 cs();
		ck("write", {f, f ? {v[6:0], r} : 15'h0000},
			{file_wr_en, f ? {file_addr, file_wr_data} : 15'h0000});
	endtask
	// a literal add follows the test at once, in the slot that runs idle if the skip is taken
	task sk(input logic [3:0] o, input logic [7:0] v, input logic [2:0] b);
		logic k;
		k = v[b] ^ (o == 4'h8);
		@(posedge clk) drv(o, v, b, 1'b0, 1'b0);
		@(posedge clk) drv(4'h1, 8'h01, 3'h0, 1'b0, 1'b0);
		#1 ck("idle", {15'h0000, k}, {15'h0000, idle_cycle});
		ck("ready", {15'h0000, !k}, {15'h0000, instr_ready});
		if (!k)
			{c, n, z, a} = {a == 8'hff, a[3:0] == 4'hf, a == 8'hff, a + 8'h01};
		@(posedge clk) instr_valid <= 1'b0;
		#1 cs();
	endtask
	task stop_test;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		#1 cs();
		foreach (lv[i]) op(4'h1, lv[i], 3'h0, 1'b0, 1'b0);
		op(4'h3, 8'hf0, 3'h0, 1'b1, 1'b0);
		op(4'h3, 8'h0f, 3'h0, 1'b0, 1'b0);
		op(4'h2, 8'h7e, 3'h0, 1'b0, 1'b0);
		op(4'h2, 8'h99, 3'h0, 1'b1, 1'b1);
		op(4'h4, 8'h5a, 3'h0, 1'b1, 1'b1);
		op(4'h4, 8'hc3, 3'h0, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			op(4'h5, 8'hff, 3'(i), 1'b0, 1'b0);
			op(4'h6, 8'h00, 3'(i), 1'b0, 1'b1);
		end
		for (int i = 0; i < 4; i++)
			sk(i[1] ? 4'h8 : 4'h7, {8{i[0]}}, 3'(i * 3));
		stop_test();
	end

	initial
	begin
		#20000;
		n_fail++;
		stop_test();
	end
endmodule
